// *** udl_regs.svh ***
// register offsets, field positions, reset values and codes of the dual channel register decode
`ifndef UDL_REGS_SVH
`define UDL_REGS_SVH

// ----------------------------------------------------------------
// offsets (three-bit host address)
// ----------------------------------------------------------------
`define UDL_ADDR_0              3'h0
`define UDL_ADDR_1              3'h1
`define UDL_ADDR_2              3'h2
`define UDL_ADDR_3              3'h3
`define UDL_ADDR_4              3'h4
`define UDL_ADDR_5              3'h5
`define UDL_ADDR_6              3'h6
`define UDL_ADDR_7              3'h7

// ----------------------------------------------------------------
// field positions and special values
// ----------------------------------------------------------------
`define UDL_LC_ENHANCED_VAL     8'hBF
`define UDL_LC_DIVISOR_BIT      7
`define UDL_MC_DTR_BIT          0
`define UDL_MC_RTS_BIT          1
`define UDL_MC_OUT1_BIT         2
`define UDL_MC_OUT2_BIT         3
`define UDL_MC_LOOPBACK_BIT     4
`define UDL_EF_ENHANCED_BIT     4
`define UDL_EF_AUTO_RTS_BIT     6
`define UDL_EF_AUTO_CTS_BIT     7
`define UDL_FCT_LEVEL_SEL_BIT   6

// ----------------------------------------------------------------
// reset values and read-only codes (codes are arbitrary)
// ----------------------------------------------------------------
`define UDL_REG_RST             8'h00
`define UDL_DIV_ZERO            8'h00
`define UDL_UNMAPPED_READ       8'h00
`define UDL_REVISION_CODE       8'h01
`define UDL_IDENT_CODE          8'h5A

`endif

// *** udl_pkg.sv ***
// types shared by the dual channel register decode and loopback block
package udl_pkg;

    // host parallel bus pins
    typedef struct packed {
        logic       cs_n;
        logic       chan_sel;
        logic       rd_n;
        logic       wr_n;
        logic [2:0] addr;
        logic [7:0] data;
    } udl_host_pins_t;

    // per channel modem and serial input pins
    typedef struct packed {
        logic rx;
        logic cts_n;
        logic dsr_n;
        logic cd_n;
        logic ri_n;
    } udl_modem_pins_t;

    // per channel status from the uart core
    typedef struct packed {
        logic [7:0] rx_holding;
        logic [7:0] interrupt_status;
        logic [7:0] line_status;
        logic [7:0] fifo_level;
        logic       tsr_serial;
    } udl_core_stat_t;

    // per channel strobes and loopback routing to the uart core
    typedef struct packed {
        logic       tx_write;
        logic       rx_read;
        logic       fifo_ctrl_write;
        logic       trigger_write;
        logic       loopback;
        logic       auto_rts_en;
        logic       auto_cts_en;
        logic       rx_serial;
        logic       cts_n;
        logic       dsr_n;
        logic       cd_n;
        logic       ri_n;
        logic [7:0] wdata;
    } udl_core_ctrl_t;

    // per channel output pins
    typedef struct packed {
        logic tx;
        logic rts_n;
        logic dtr_n;
    } udl_line_out_t;

    // per channel register set
    typedef struct packed {
        logic [7:0] divisor_low;
        logic [7:0] divisor_high;
        logic [7:0] alternate_function;
        logic [7:0] divisor_fraction;
        logic [7:0] interrupt_enable;
        logic [7:0] line_control;
        logic [7:0] modem_control;
        logic [7:0] scratch_pad;
        logic [7:0] enhanced_mode_select;
        logic [7:0] fifo_trigger_level;
        logic [7:0] feature_control;
        logic [7:0] enhanced_function;
        logic [7:0] resume_char_1;
        logic [7:0] resume_char_2;
        logic [7:0] stop_char_1;
        logic [7:0] stop_char_2;
        logic [3:0] modem_delta;
    } udl_chan_regs_t;

    typedef enum logic [4:0] {
        SEL_NONE, SEL_RX_HOLDING, SEL_TX_HOLDING, SEL_DIV_LOW, SEL_DIV_HIGH,
        SEL_REVISION, SEL_IDENT, SEL_ALT_FUNC, SEL_DIV_FRAC, SEL_INT_ENABLE,
        SEL_INT_STATUS, SEL_FIFO_CTRL, SEL_LINE_CTRL, SEL_MODEM_CTRL,
        SEL_LINE_STATUS, SEL_MODEM_STATUS, SEL_SCRATCH, SEL_LEVEL_ALT,
        SEL_MODE_SELECT, SEL_TRIGGER, SEL_LEVEL_COUNT, SEL_FEATURE,
        SEL_ENH_FUNC, SEL_RESUME_1, SEL_RESUME_2, SEL_STOP_1, SEL_STOP_2
    } udl_sel_t;

    typedef enum logic [1:0] {
        PH_IDLE, PH_READ, PH_WRITE
    } udl_phase_t;

    typedef struct packed {
        udl_host_pins_t        host;
        udl_modem_pins_t [1:0] modem;
    } udl_sync_t;

    typedef struct packed {
        udl_sync_t             s1;
        udl_sync_t             s2;
        udl_phase_t            phase;
        logic                  chan;
        logic [2:0]            addr;
        logic [7:0]            wdata;
        logic [7:0]            rdata;
        logic                  oe;
        udl_chan_regs_t [1:0]  regs;
        udl_core_ctrl_t [1:0]  ctrl;
        udl_line_out_t  [1:0]  line;
    } udl_state_t;

endpackage

// *** udl_reg_decode.sv ***
// dual channel register decode with internal loopback routing
//
// Overview of operation
// [RULE_01] modem control bit 4 enables loopback
// [RULE_02] transmit serial output feeds receiver internally
// [RULE_03] loopback holds tx, rts, dtr; ignores modem inputs
// [RULE_04] no automatic rts/cts flow control in loopback
// [RULE_05] host keeps rx pin high during loopback
// [RULE_06] separate register set per channel, chip select
// [RULE_07] address 0 normal: rx read, tx write
// [RULE_08] divisor access: address 0 low, 1 high
// [RULE_09] divisor access address 2: alternate or fraction
// [RULE_10] zero divisor reads revision and identification codes
// [RULE_11] address 1 normal: interrupt enable register
// [RULE_12] address 2: interrupt status read, fifo control write
// [RULE_13] line control and modem control always accessible; in the enhanced set address 4 selects resume char 1, not modem control
// [RULE_14] line and modem status are read only
// [RULE_15] address 7: scratch pad or fifo level
// [RULE_16] address 7 write: enhanced mode select
// [RULE_17] enhanced set address 0: trigger write, level read
// [RULE_18] enhanced set: feature control, enhanced function
// [RULE_19] enhanced set addresses 4-7: resume, stop characters
// [RULE_20] all registers eight bits, single access
`timescale 1ns/1ns
`include "udl_regs.svh"
`default_nettype none

module udl_reg_decode (
    input  wire logic                           ref_clk_i,   // 25 MHz clock
    input  wire logic                           rst_i,       // async reset, high
    input  wire udl_pkg::udl_host_pins_t        host_i,      // host bus pins
    input  wire udl_pkg::udl_modem_pins_t [1:0] modem_i,     // serial and modem pins
    input  wire udl_pkg::udl_core_stat_t  [1:0] core_stat_i, // uart core status
    output var  logic [7:0]                     data_o,      // host read data
    output var  logic                           data_oe_o,   // host data drive enable
    output var  udl_pkg::udl_core_ctrl_t  [1:0] core_ctrl_o, // uart core strobes
    output var  udl_pkg::udl_line_out_t   [1:0] line_o,      // serial and modem outputs
    output var  udl_pkg::udl_chan_regs_t  [1:0] regs_o       // register contents
);
    import udl_pkg::*;

    udl_state_t st_ff;
    udl_state_t nxt_st;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic udl_sel_t reg_decode(
        input logic [2:0] addr,
        input logic [7:0] line_ctrl,
        input logic       enh_bit,
        input logic       level_sel,
        input logic       div_zero,
        input logic       is_write
    );
        logic     enh;
        logic     div_acc;
        udl_sel_t sel;
        enh     = (line_ctrl == `UDL_LC_ENHANCED_VAL);
        div_acc = line_ctrl[`UDL_LC_DIVISOR_BIT] & ~enh;
        sel     = SEL_NONE;
        case (addr)
            `UDL_ADDR_0: begin
                // [RULE_17] trigger and level count
                if (enh) begin
                    sel = is_write ? SEL_TRIGGER : SEL_LEVEL_COUNT;
                // [RULE_08] [RULE_10] divisor or codes
                end else if (div_acc) begin
                    sel = (!is_write && div_zero) ? SEL_REVISION : SEL_DIV_LOW;
                // [RULE_07] holding registers
                end else begin
                    sel = is_write ? SEL_TX_HOLDING : SEL_RX_HOLDING;
                end
            end
            `UDL_ADDR_1: begin
                // [RULE_18] feature control
                if (enh) begin
                    sel = SEL_FEATURE;
                // [RULE_08] [RULE_10] divisor or codes
                end else if (div_acc) begin
                    sel = (!is_write && div_zero) ? SEL_IDENT : SEL_DIV_HIGH;
                // [RULE_11] interrupt enable
                end else begin
                    sel = SEL_INT_ENABLE;
                end
            end
            `UDL_ADDR_2: begin
                // [RULE_18] enhanced function
                if (enh) begin
                    sel = SEL_ENH_FUNC;
                // [RULE_09] alternate or fractional
                end else if (div_acc) begin
                    sel = enh_bit ? SEL_DIV_FRAC : SEL_ALT_FUNC;
                // [RULE_12] status read, control write
                end else begin
                    sel = is_write ? SEL_FIFO_CTRL : SEL_INT_STATUS;
                end
            end
            // [RULE_13] line control unconditional
            `UDL_ADDR_3: begin
                sel = SEL_LINE_CTRL;
            end
            // [RULE_13] [RULE_19] modem control or resume
            `UDL_ADDR_4: begin
                sel = enh ? SEL_RESUME_1 : SEL_MODEM_CTRL;
            end
            // [RULE_14] [RULE_19] line status read only
            `UDL_ADDR_5: begin
                if (enh) begin
                    sel = SEL_RESUME_2;
                end else begin
                    sel = is_write ? SEL_NONE : SEL_LINE_STATUS;
                end
            end
            // [RULE_14] [RULE_19] modem status read only
            `UDL_ADDR_6: begin
                if (enh) begin
                    sel = SEL_STOP_1;
                end else begin
                    sel = is_write ? SEL_NONE : SEL_MODEM_STATUS;
                end
            end
            `UDL_ADDR_7: begin
                // [RULE_19] second stop character
                if (enh) begin
                    sel = SEL_STOP_2;
                // [RULE_15] [RULE_16] scratch, level, mode select
                end else if (level_sel) begin
                    sel = is_write ? SEL_MODE_SELECT : SEL_LEVEL_ALT;
                end else begin
                    sel = SEL_SCRATCH;
                end
            end
            default: begin
                sel = SEL_NONE;
            end
        endcase
        return sel;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        udl_host_pins_t  h;
        udl_chan_regs_t  r;
        udl_core_stat_t  s;
        udl_sel_t        sel;
        logic            ch;
        logic            loop;
        logic [3:0]      prev_in;
        logic [3:0]      new_in;
        h       = st_ff.s2.host;
        r       = '0;
        s       = '0;
        sel     = SEL_NONE;
        ch      = 1'b0;
        loop    = 1'b0;
        prev_in = '0;
        new_in  = '0;
        nxt_st  = st_ff;

        // two-flop pin synchronisers
        nxt_st.s1.host  = host_i;
        nxt_st.s1.modem = modem_i;
        nxt_st.s2       = st_ff.s1;

        for (int c = 0; c < 2; c++) begin
            nxt_st.ctrl[c].tx_write        = 1'b0;
            nxt_st.ctrl[c].rx_read         = 1'b0;
            nxt_st.ctrl[c].fifo_ctrl_write = 1'b0;
            nxt_st.ctrl[c].trigger_write   = 1'b0;
        end

        case (st_ff.phase)
            PH_IDLE: begin
                // [RULE_06] chip select and channel select
                ch = h.chan_sel;
                r  = st_ff.regs[ch];
                s  = core_stat_i[ch];
                if (!h.cs_n && !h.rd_n) begin
                    sel = reg_decode(h.addr, r.line_control,
                                     r.enhanced_function[`UDL_EF_ENHANCED_BIT],
                                     r.feature_control[`UDL_FCT_LEVEL_SEL_BIT],
                                     (r.divisor_low == `UDL_DIV_ZERO) &&
                                     (r.divisor_high == `UDL_DIV_ZERO), 1'b0);
                    nxt_st.oe    = 1'b1;
                    nxt_st.phase = PH_READ;
                    // [RULE_20] eight-bit read mux
                    case (sel)
                        SEL_RX_HOLDING: begin
                            nxt_st.rdata           = s.rx_holding;
                            nxt_st.ctrl[ch].rx_read = 1'b1;
                        end
                        SEL_DIV_LOW:      nxt_st.rdata = r.divisor_low;
                        SEL_DIV_HIGH:     nxt_st.rdata = r.divisor_high;
                        SEL_REVISION:     nxt_st.rdata = `UDL_REVISION_CODE;
                        SEL_IDENT:        nxt_st.rdata = `UDL_IDENT_CODE;
                        SEL_ALT_FUNC:     nxt_st.rdata = r.alternate_function;
                        SEL_DIV_FRAC:     nxt_st.rdata = r.divisor_fraction;
                        SEL_INT_ENABLE:   nxt_st.rdata = r.interrupt_enable;
                        SEL_INT_STATUS:   nxt_st.rdata = s.interrupt_status;
                        SEL_LINE_CTRL:    nxt_st.rdata = r.line_control;
                        SEL_MODEM_CTRL:   nxt_st.rdata = r.modem_control;
                        SEL_LINE_STATUS:  nxt_st.rdata = s.line_status;
                        SEL_MODEM_STATUS: begin
                            nxt_st.rdata = {~st_ff.ctrl[ch].cd_n, ~st_ff.ctrl[ch].ri_n,
                                            ~st_ff.ctrl[ch].dsr_n, ~st_ff.ctrl[ch].cts_n,
                                            r.modem_delta};
                            nxt_st.regs[ch].modem_delta = '0;
                        end
                        SEL_SCRATCH:      nxt_st.rdata = r.scratch_pad;
                        SEL_LEVEL_ALT:    nxt_st.rdata = s.fifo_level;
                        SEL_LEVEL_COUNT:  nxt_st.rdata = s.fifo_level;
                        SEL_FEATURE:      nxt_st.rdata = r.feature_control;
                        SEL_ENH_FUNC:     nxt_st.rdata = r.enhanced_function;
                        SEL_RESUME_1:     nxt_st.rdata = r.resume_char_1;
                        SEL_RESUME_2:     nxt_st.rdata = r.resume_char_2;
                        SEL_STOP_1:       nxt_st.rdata = r.stop_char_1;
                        SEL_STOP_2:       nxt_st.rdata = r.stop_char_2;
                        default:          nxt_st.rdata = `UDL_UNMAPPED_READ;
                    endcase
                end else if (!h.cs_n && !h.wr_n) begin
                    nxt_st.chan  = h.chan_sel;
                    nxt_st.addr  = h.addr;
                    nxt_st.wdata = h.data;
                    nxt_st.phase = PH_WRITE;
                end
            end
            PH_READ: begin
                if (h.rd_n) begin
                    nxt_st.oe    = 1'b0;
                    nxt_st.phase = PH_IDLE;
                end
            end
            PH_WRITE: begin
                if (!h.wr_n) begin
                    // keep data seen while strobe still low
                    nxt_st.wdata = h.data;
                end else begin
                    ch  = st_ff.chan;
                    r   = st_ff.regs[ch];
                    sel = reg_decode(st_ff.addr, r.line_control,
                                     r.enhanced_function[`UDL_EF_ENHANCED_BIT],
                                     r.feature_control[`UDL_FCT_LEVEL_SEL_BIT],
                                     1'b0, 1'b1);
                    nxt_st.ctrl[ch].wdata = st_ff.wdata;
                    nxt_st.phase          = PH_IDLE;
                    // [RULE_20] eight-bit write decode
                    case (sel)
                        SEL_TX_HOLDING:  nxt_st.ctrl[ch].tx_write = 1'b1;
                        SEL_DIV_LOW:     nxt_st.regs[ch].divisor_low = st_ff.wdata;
                        SEL_DIV_HIGH:    nxt_st.regs[ch].divisor_high = st_ff.wdata;
                        SEL_ALT_FUNC:    nxt_st.regs[ch].alternate_function = st_ff.wdata;
                        SEL_DIV_FRAC:    nxt_st.regs[ch].divisor_fraction = st_ff.wdata;
                        SEL_INT_ENABLE:  nxt_st.regs[ch].interrupt_enable = st_ff.wdata;
                        SEL_FIFO_CTRL:   nxt_st.ctrl[ch].fifo_ctrl_write = 1'b1;
                        SEL_LINE_CTRL:   nxt_st.regs[ch].line_control = st_ff.wdata;
                        SEL_MODEM_CTRL:  nxt_st.regs[ch].modem_control = st_ff.wdata;
                        SEL_SCRATCH:     nxt_st.regs[ch].scratch_pad = st_ff.wdata;
                        SEL_MODE_SELECT: nxt_st.regs[ch].enhanced_mode_select = st_ff.wdata;
                        SEL_TRIGGER: begin
                            nxt_st.regs[ch].fifo_trigger_level = st_ff.wdata;
                            nxt_st.ctrl[ch].trigger_write      = 1'b1;
                        end
                        SEL_FEATURE:     nxt_st.regs[ch].feature_control = st_ff.wdata;
                        SEL_ENH_FUNC:    nxt_st.regs[ch].enhanced_function = st_ff.wdata;
                        SEL_RESUME_1:    nxt_st.regs[ch].resume_char_1 = st_ff.wdata;
                        SEL_RESUME_2:    nxt_st.regs[ch].resume_char_2 = st_ff.wdata;
                        SEL_STOP_1:      nxt_st.regs[ch].stop_char_1 = st_ff.wdata;
                        SEL_STOP_2:      nxt_st.regs[ch].stop_char_2 = st_ff.wdata;
                        default: begin
                        end
                    endcase
                end
            end
            default: begin
                nxt_st.oe    = 1'b0;
                nxt_st.phase = PH_IDLE;
            end
        endcase

        // ----------------------------------------------------------------
        // per channel loopback routing
        // ----------------------------------------------------------------
        for (int c = 0; c < 2; c++) begin
            r    = st_ff.regs[c];
            // [RULE_01] loopback enable
            loop = r.modem_control[`UDL_MC_LOOPBACK_BIT];
            nxt_st.ctrl[c].loopback  = loop;
            // [RULE_02] transmit output to receiver
            nxt_st.ctrl[c].rx_serial = loop ? core_stat_i[c].tsr_serial
                                            : st_ff.s2.modem[c].rx;
            // [RULE_03] modem inputs ignored
            if (loop) begin
                nxt_st.ctrl[c].cts_n = ~r.modem_control[`UDL_MC_RTS_BIT];
                nxt_st.ctrl[c].dsr_n = ~r.modem_control[`UDL_MC_DTR_BIT];
                nxt_st.ctrl[c].ri_n  = ~r.modem_control[`UDL_MC_OUT1_BIT];
                nxt_st.ctrl[c].cd_n  = ~r.modem_control[`UDL_MC_OUT2_BIT];
            end else begin
                nxt_st.ctrl[c].cts_n = st_ff.s2.modem[c].cts_n;
                nxt_st.ctrl[c].dsr_n = st_ff.s2.modem[c].dsr_n;
                nxt_st.ctrl[c].ri_n  = st_ff.s2.modem[c].ri_n;
                nxt_st.ctrl[c].cd_n  = st_ff.s2.modem[c].cd_n;
                // [RULE_03] pins follow only outside loopback
                nxt_st.line[c].tx    = core_stat_i[c].tsr_serial;
                nxt_st.line[c].rts_n = ~r.modem_control[`UDL_MC_RTS_BIT];
                nxt_st.line[c].dtr_n = ~r.modem_control[`UDL_MC_DTR_BIT];
            end
            // [RULE_04] auto flow control gated off
            nxt_st.ctrl[c].auto_rts_en = r.enhanced_function[`UDL_EF_AUTO_RTS_BIT] & ~loop;
            nxt_st.ctrl[c].auto_cts_en = r.enhanced_function[`UDL_EF_AUTO_CTS_BIT] & ~loop;
            // change flags: a set beats a status read clear
            prev_in = {st_ff.ctrl[c].cd_n, st_ff.ctrl[c].ri_n,
                       st_ff.ctrl[c].dsr_n, st_ff.ctrl[c].cts_n};
            new_in  = {nxt_st.ctrl[c].cd_n, nxt_st.ctrl[c].ri_n,
                       nxt_st.ctrl[c].dsr_n, nxt_st.ctrl[c].cts_n};
            nxt_st.regs[c].modem_delta = nxt_st.regs[c].modem_delta | (prev_in ^ new_in);
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff                 <= '0;
            st_ff.s1.host.cs_n    <= 1'b1;
            st_ff.s1.host.rd_n    <= 1'b1;
            st_ff.s1.host.wr_n    <= 1'b1;
            st_ff.s2.host.cs_n    <= 1'b1;
            st_ff.s2.host.rd_n    <= 1'b1;
            st_ff.s2.host.wr_n    <= 1'b1;
            st_ff.phase           <= PH_IDLE;
            for (int c = 0; c < 2; c++) begin
                st_ff.line[c].tx       <= 1'b1;
                st_ff.line[c].rts_n    <= 1'b1;
                st_ff.line[c].dtr_n    <= 1'b1;
                st_ff.ctrl[c].rx_serial <= 1'b1;
                st_ff.ctrl[c].cts_n    <= 1'b1;
                st_ff.ctrl[c].dsr_n    <= 1'b1;
                st_ff.ctrl[c].cd_n     <= 1'b1;
                st_ff.ctrl[c].ri_n     <= 1'b1;
                st_ff.s1.modem[c]      <= '1;
                st_ff.s2.modem[c]      <= '1;
                st_ff.regs[c]          <= {{16{`UDL_REG_RST}}, 4'h0};
            end
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign data_o      = st_ff.rdata;
    assign data_oe_o   = st_ff.oe;
    assign core_ctrl_o = st_ff.ctrl;
    assign line_o      = st_ff.line;
    assign regs_o      = st_ff.regs;

endmodule

`default_nettype wire

// *** udl_reg_decode_assertions.sv ***
// port assertions for register decode
`timescale 1ns/1ns
`default_nettype none
module udl_reg_decode_assertions (
    input wire logic                          ref_clk_i,   // clock
    input wire logic                          rst_i,       // reset
    input wire udl_pkg::udl_host_pins_t       host_i,      // bus
    input wire udl_pkg::udl_core_stat_t [1:0] core_stat_i, // core
    input wire logic                          data_oe_o,   // drive
    input wire udl_pkg::udl_core_ctrl_t [1:0] core_ctrl_o, // ctrl
    input wire udl_pkg::udl_line_out_t  [1:0] line_o,      // pins
    input wire udl_pkg::udl_chan_regs_t [1:0] regs_o       // regs
);
    import udl_pkg::*;
    wire       lb = core_ctrl_o[0].loopback;
    wire [7:0] mc = regs_o[0].modem_control;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence rd_go;
        !host_i.cs_n && !host_i.rd_n && $past(host_i.rd_n);
    endsequence
    sequence mc_calm;
        $stable(mc)[*2];
    endsequence
    loop_enable_a: assert property (mc_calm |-> lb == mc[4])
        else $error("loopback flag wrong");
    loop_route_a: assert property (lb && $past(lb) |->
        core_ctrl_o[0].rx_serial == $past(core_stat_i[0].tsr_serial))
        else $error("loopback serial wrong");
    pin_hold_a: assert property (lb[*3] |-> $stable(line_o[0]))
        else $error("line pins moved");
    modem_ignore_a: assert property (lb[*2] ##0 mc_calm |->
        core_ctrl_o[0].cts_n == !mc[1] && core_ctrl_o[0].dsr_n == !mc[0])
        else $error("modem input not ignored");
    no_auto_a: assert property (lb[*2] |->
        !core_ctrl_o[0].auto_rts_en && !core_ctrl_o[0].auto_cts_en)
        else $error("auto flow active");
    read_drive_a: assert property (rd_go |-> ##3 data_oe_o)
        else $error("read not answered");
    read_end_a: assert property ($rose(host_i.rd_n) |-> data_oe_o[*3] ##1 !data_oe_o)
        else $error("data drive timing wrong");
    tx_pulse_a: assert property (core_ctrl_o[0].tx_write |->
        ($past(host_i.wr_n, 3) && !$past(host_i.wr_n, 4)) ##1 !core_ctrl_o[0].tx_write)
        else $error("transmit pulse wrong");
endmodule
bind udl_reg_decode udl_reg_decode_assertions chk_u (.ref_clk_i, .rst_i, .host_i,
    .core_stat_i, .data_oe_o, .core_ctrl_o, .line_o, .regs_o);
`default_nettype wire

// *** udl_host_model.sv ***
// host processor bus master model
`timescale 1ns/1ns
`default_nettype none
module udl_host_model (
    input  wire logic                    clk_i,  // bus clock
    output var  udl_pkg::udl_host_pins_t host_o  // host pins
);
    import udl_pkg::*;
    initial host_o = '1;
    task automatic acc(input logic ch, input logic rd, input logic [2:0] a,
                       input logic [7:0] d);
        @(posedge clk_i);
        host_o <= {1'b0, ch, !rd, rd, a, rd ? ~host_o.data : d};
        repeat (4) @(posedge clk_i);
        host_o.rd_n <= 1'b1;
        host_o.wr_n <= 1'b1;
        repeat (4) @(posedge clk_i);
        host_o.cs_n <= 1'b1;
        host_o.data <= ~host_o.data;
    endtask
endmodule
`default_nettype wire

// *** tb_uart_register_decode_loopback.sv ***
// self-checking bench for register decode
`timescale 1ns/1ns
`include "udl_regs.svh"
`default_nettype none
module tb_uart_register_decode_loopback;
    import udl_pkg::*;
    logic                  clk;
    logic                  rst;
    logic                  c;
    logic [7:0]            v;
    udl_host_pins_t        host;
    udl_modem_pins_t [1:0] modem;
    udl_core_stat_t  [1:0] stat;
    logic [7:0]            dout;
    logic                  oe;
    logic                  oe_q = 1'b0;
    logic [7:0]            q[$];
    logic [16:0]           r = 17'h16E4B;
    int                    err_count = 0;
    int                    total_checks = 0;
    int                    cyc = 0;
    udl_host_model hm (.clk_i(clk), .host_o(host));
    udl_reg_decode dut_u (.ref_clk_i(clk), .rst_i(rst), .host_i(host), .modem_i(modem),
        .core_stat_i(stat), .data_o(dout), .data_oe_o(oe), .core_ctrl_o(),
        .line_o(), .regs_o());
    function automatic logic [7:0] rnd();
        r = {r[15:0], r[16] ^ r[13]};
        return r[7:0];
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic complete_run();
        if (q.size() != 0)
            err_count++;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        hm.acc(c, 1'b0, a, d);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        q.push_back(e);
        hm.acc(c, 1'b1, a, 8'h00);
    endtask
    task automatic rw(input logic [2:0] a);
        logic [7:0] d;
        d = rnd() | 8'h01;
        wr(a, d);
        rd(a, d);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(negedge clk) begin
        cyc++;
        if (oe && !oe_q)
            chk("read data", q.size() ? q.pop_front() : ~dout, dout);
        oe_q = oe;
        if (cyc == 4000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        rst = 1'b1;
        modem = '1;
        stat = '0;
        c = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) begin
            v = rnd();
            stat[c] <= {v, ~v, v ^ 8'h5A, v + 8'h11, 1'b1};
            wr(3'h3, 8'h03);
            rw(3'h1);
            rw(3'h7);
            rd(3'h0, v);
            wr(3'h0, v);
            rd(3'h2, ~v);
            rd(3'h5, v ^ 8'h5A);
            rd(3'h3, 8'h03);
            wr(3'h3, 8'h80);
            rd(3'h0, `UDL_REVISION_CODE);
            rd(3'h1, `UDL_IDENT_CODE);
            for (int a = 0; a < 3; a++)
                rw(3'(a));
            wr(3'h3, 8'hBF);
            rd(3'h0, v + 8'h11);
            for (int a = 4; a < 8; a++)
                rw(3'(a));
            wr(3'h1, 8'h40);
            rd(3'h1, 8'h40);
            wr(3'h2, 8'hD0);
            rd(3'h2, 8'hD0);
            wr(3'h3, 8'h80);
            rw(3'h2);
            wr(3'h3, 8'h03);
            wr(3'h7, rnd());
            rd(3'h7, v + 8'h11);
            wr(3'h4, 8'h13);
            repeat (30) begin
                @(posedge clk);
                v = rnd();
                stat[c].tsr_serial <= v[0];
                modem[c] <= {1'b1, v[4:1]};
            end
            rd(3'h4, 8'h13);
            rd(3'h6, 8'h33);
            wr(3'h4, 8'h00);
            c = ~c;
        end
        complete_run();
    end
endmodule
`default_nettype wire
